// File: hw/pmw_cfg.svh
// Purpose: constants of the program memory map and wait-state block
// Assumes: 16-bit memory-mapped registers on the CPU data-space port
// Notes: offsets, field positions, reset values and limits only
//
// Behaviour
// - boot mode low: start at ROM FF80h
// - 4K ROM F000h-FFFFh, FF00h-FF7Fh test-reserved
// - two 8K RAM blocks, two accesses per cycle
// - RAM at data 0080h-3FFFh, overlay adds program
// - vector load to PC, four-word slots
// - vector base relocatable on 128-word pages
// - reset sets vector pointer all ones
// - twenty program address lines, sixteen 64K pages
// - page register at 001Eh, resets to zero
// - far instructions load page from 20-bit target
// - program read/write use full 20-bit address
// - only far loads and 001Eh writes change page; stay within page
// - overlay decides lower 16K of every page
// - at most fourteen waits, ready extends further
// - all-zero wait fields gate counter clock off
// - five 3-bit fields of base waits
// - multiplier scales base count by one or two
// - reset gives seven waits everywhere
// - wait-state config register at 0028h
// - field layout; bit 15 extended program select
// - extended select: lower program field covers all
// - multiplier bit 0 at 002Bh, resets zero
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH

`define PMW_MMR_PROCESSOR_MODE_REG 16'h001d
`define PMW_MMR_XPC 16'h001e
`define PMW_MMR_WAIT_STATE_CONFIG 16'h0028
`define PMW_MMR_WAIT_STATE_CONTROL 16'h002b
`define PMW_MMR_TOP 16'h007f

`define PMW_RAM_LO 16'h0080
`define PMW_RAM_HI 16'h3fff
`define PMW_ROM_LO 16'hf000
`define PMW_ROM_TEST_LO 16'hff00
`define PMW_ROM_TEST_HI 16'hff7f
`define PMW_RESET_VEC 16'hff80

`define PMW_PROCESSOR_MODE_REG_RST 16'hff80
`define PMW_XPC_RST 4'h0
`define PMW_WAIT_STATE_CONFIG_RST 16'h7fff
`define PMW_WAIT_MULTIPLIER_RST 1'b0

`define PMW_VECTOR_PAGE_POINTER_MSB 15
`define PMW_VECTOR_PAGE_POINTER_LSB 7
`define PMW_MPMC_BIT 6
`define PMW_RAM_OVERLAY_BIT_BIT 5
`define PMW_XPA_BIT 15
`define PMW_WS_IO_LSB 12
`define PMW_WS_DHI_LSB 9
`define PMW_WS_DLO_LSB 6
`define PMW_WS_PHI_LSB 3
`define PMW_WS_PLO_LSB 0
`define PMW_WS_FIELDS_MSB 14
`define PMW_WAIT_MULTIPLIER_BIT 0

`define PMW_WAIT_MAX 4'he

`endif

// File: hw/pmw_dual_access_ram_blk.sv
// Purpose: one dual-access RAM block, one read/write and one read port
// Assumes: at most one write per cycle, both reads asynchronous
// Notes: a read of the word being written returns the old word
`timescale 1ns/1ps
module pmw_dual_access_ram_blk #(
  parameter int AW = 13,
  parameter int DW = 16
) (
  // clock
  input wire logic sys_clk_i,
  // port a: read or write
  input wire logic a_we_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [DW-1:0] a_wdata_i,
  output logic [DW-1:0] a_rdata_o,
  // port b: read
  input wire logic [AW-1:0] b_addr_i,
  output logic [DW-1:0] b_rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_comb begin
    a_rdata_o = mem[a_addr_i];
    b_rdata_o = mem[b_addr_i];
  end

  always_ff @(posedge sys_clk_i) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
  end

endmodule // pmw_dual_access_ram_blk

// File: hw/pmw_pkg.sv
// Purpose: shared types of the program memory map block
// Assumes: used with pmw_cfg.svh for all numeric constants
// Notes: access space codes follow the CPU request port
package pmw_pkg;

  typedef enum logic [1:0] {
    PMW_SP_PROG,
    PMW_SP_DATA,
    PMW_SP_IO
  } pmw_space_t;

  typedef enum logic {
    PMW_ST_IDLE,
    PMW_ST_EXT
  } pmw_state_t;

endpackage

// File: hw/pmw_top.sv
// Purpose: program/data memory map, vector and page control, wait states
// Assumes: one CPU access port plus one data read port, one external bus
// Notes: CPU access-port requests taken in idle only; one external access at a time
`timescale 1ns/1ps
`include "pmw_cfg.svh"
module pmw_top
  import pmw_pkg::*;
#(
  parameter logic [15:0] ROM_FILL = 16'h0000,
  parameter int NBLK = 2,
  parameter int BLK_AW = 13
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // strap
  input wire logic boot_mode_select_i,
  // cpu access port
  input wire logic acc_req_i,
  input wire logic [1:0] acc_space_i,
  input wire logic acc_wr_i,
  input wire logic acc_full_i,
  input wire logic [3:0] acc_addr_hi_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic [15:0] acc_wdata_i,
  output logic acc_ack_o,
  output logic [15:0] acc_rdata_o,
  // cpu second data read port
  input wire logic aux_req_i,
  input wire logic [15:0] aux_addr_i,
  output logic aux_ack_o,
  output logic [15:0] aux_rdata_o,
  // program flow
  input wire logic vec_req_i,
  input wire logic [4:0] vec_num_i,
  input wire logic far_load_i,
  input wire logic [19:0] far_target_i,
  output logic pc_load_o,
  output logic [15:0] pc_load_addr_o,
  output logic [3:0] prog_page_o,
  // external bus
  output logic ext_req_o,
  output logic ext_wr_o,
  output logic [1:0] ext_space_o,
  output logic [19:0] ext_addr_o,
  output logic [15:0] ext_wdata_o,
  input wire logic [15:0] ext_rdata_i,
  input wire logic ext_ready_i
);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // control registers
  logic [15:0] processor_mode_reg_r, processor_mode_reg_nxt;
  logic [3:0] xpc_r, xpc_nxt;
  logic [15:0] wait_state_config_r, wait_state_config_nxt;
  logic wait_multiplier_r, wait_multiplier_nxt;
  logic strap_done_r, strap_done_nxt;
  logic pc_load_r, pc_load_nxt;
  logic [15:0] pc_addr_r, pc_addr_nxt;
  // access sequencer
  pmw_state_t state_r, state_nxt;
  logic acc_ack_r, acc_ack_nxt;
  logic [15:0] acc_rdata_r, acc_rdata_nxt;
  logic aux_ack_r, aux_ack_nxt;
  logic [15:0] aux_rdata_r, aux_rdata_nxt;
  logic ext_req_r, ext_req_nxt;
  logic ext_wr_r, ext_wr_nxt;
  logic [1:0] ext_space_r, ext_space_nxt;
  logic [19:0] ext_addr_r, ext_addr_nxt;
  logic [15:0] ext_wdata_r, ext_wdata_nxt;
  // decode
  pmw_space_t space;
  logic is_prog, is_data, is_io, take, take_ext;
  logic [19:0] prog_addr;
  logic ram_overlay_bit, extended_program_wait_select, mode_mp;
  logic hit_mmr, hit_ram, hit_rom, aux_hit, mmr_wr, far_ok;
  logic [2:0] ws_base;
  logic [3:0] ws_cnt;
  logic ws_gate, ws_done;
  logic [15:0] mmr_rd, rom_rd;
  logic [15:0] ram_a_rd [NBLK];
  logic [15:0] ram_b_rd [NBLK];

  function automatic logic [15:0] rom_word(input logic [15:0] a);
    // mask contents fixed at manufacture; test words read as zero
    if (a >= `PMW_ROM_TEST_LO && a <= `PMW_ROM_TEST_HI) begin
      rom_word = 16'h0000;
    end else begin
      rom_word = ROM_FILL ^ {4'h0, a[11:0]};
    end
  endfunction

  always_comb begin
    space = pmw_space_t'(acc_space_i);
    is_prog = (space == PMW_SP_PROG);
    is_data = (space == PMW_SP_DATA);
    is_io = (space == PMW_SP_IO);
    ram_overlay_bit = processor_mode_reg_r[`PMW_RAM_OVERLAY_BIT_BIT];
    mode_mp = processor_mode_reg_r[`PMW_MPMC_BIT];
    extended_program_wait_select = wait_state_config_r[`PMW_XPA_BIT];
    // program address: full 20 bits or current page
    prog_addr = acc_full_i ? {acc_addr_hi_i, acc_addr_i} : {xpc_r, acc_addr_i};
    hit_mmr = is_data && acc_addr_i <= `PMW_MMR_TOP;
    hit_ram = (is_data && acc_addr_i >= `PMW_RAM_LO && acc_addr_i <= `PMW_RAM_HI) ||
              (is_prog && ram_overlay_bit && acc_addr_i[15:14] == 2'b00);
    hit_rom = is_prog && !mode_mp && prog_addr[19:16] == 4'h0 && acc_addr_i >= `PMW_ROM_LO;
    aux_hit = aux_addr_i >= `PMW_RAM_LO && aux_addr_i <= `PMW_RAM_HI;
    take = (state_r == PMW_ST_IDLE) && acc_req_i;
    take_ext = take && !hit_mmr && !hit_ram && !hit_rom;
    mmr_wr = take && hit_mmr && acc_wr_i;
    far_ok = strap_done_r && far_load_i && !vec_req_i;
    rom_rd = rom_word(acc_addr_i);
  end

  // wait-state range select and scaling
  always_comb begin
    if (is_io) begin
      ws_base = wait_state_config_r[`PMW_WS_IO_LSB +: 3];
    end else if (is_data) begin
      ws_base = acc_addr_i[15] ? wait_state_config_r[`PMW_WS_DHI_LSB +: 3] : wait_state_config_r[`PMW_WS_DLO_LSB +: 3];
    end else if (extended_program_wait_select || !acc_addr_i[15]) begin
      ws_base = wait_state_config_r[`PMW_WS_PLO_LSB +: 3];
    end else begin
      ws_base = wait_state_config_r[`PMW_WS_PHI_LSB +: 3];
    end
    ws_cnt = wait_multiplier_r ? {ws_base, 1'b0} : {1'b0, ws_base};
    ws_gate = |wait_state_config_r[`PMW_WS_FIELDS_MSB:0];
  end

  always_comb begin
    unique case (acc_addr_i)
      `PMW_MMR_PROCESSOR_MODE_REG: mmr_rd = processor_mode_reg_r;
      `PMW_MMR_XPC: mmr_rd = {12'h000, xpc_r};
      `PMW_MMR_WAIT_STATE_CONFIG: mmr_rd = wait_state_config_r;
      `PMW_MMR_WAIT_STATE_CONTROL: mmr_rd = {15'h0000, wait_multiplier_r};
      default: mmr_rd = 16'h0000;
    endcase
  end

  // dual-access ram: data port on a, second read port on b
  for (genvar b = 0; b < NBLK; b++) begin : g_blk
    pmw_dual_access_ram_blk #(
      .AW(BLK_AW),
      .DW(16)
    ) u_blk (
      .sys_clk_i(sys_clk_i),
      .a_we_i(take && hit_ram && acc_wr_i && acc_addr_i[BLK_AW] == 1'(b)),
      .a_addr_i(acc_addr_i[BLK_AW-1:0]),
      .a_wdata_i(acc_wdata_i),
      .a_rdata_o(ram_a_rd[b]),
      .b_addr_i(aux_addr_i[BLK_AW-1:0]),
      .b_rdata_o(ram_b_rd[b])
    );
  end

  pmw_wait_gen #(
    .CW(4)
  ) u_wait (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .start_i(take_ext),
    .count_i(ws_cnt),
    .ready_i(ext_ready_i),
    .gate_en_i(ws_gate),
    .done_o(ws_done)
  );

  // control registers next state
  always_comb begin
    processor_mode_reg_nxt = processor_mode_reg_r;
    xpc_nxt = xpc_r;
    wait_state_config_nxt = wait_state_config_r;
    wait_multiplier_nxt = wait_multiplier_r;
    strap_done_nxt = 1'b1;
    pc_load_nxt = 1'b0;
    pc_addr_nxt = pc_addr_r;
    if (mmr_wr) begin
      unique case (acc_addr_i)
        `PMW_MMR_PROCESSOR_MODE_REG: begin
          processor_mode_reg_nxt = acc_wdata_i;
          processor_mode_reg_nxt[`PMW_MPMC_BIT] = processor_mode_reg_r[`PMW_MPMC_BIT];
        end
        `PMW_MMR_XPC: xpc_nxt = acc_wdata_i[3:0];
        `PMW_MMR_WAIT_STATE_CONFIG: wait_state_config_nxt = acc_wdata_i;
        `PMW_MMR_WAIT_STATE_CONTROL: wait_multiplier_nxt = acc_wdata_i[`PMW_WAIT_MULTIPLIER_BIT];
        default: ;
      endcase
    end
    if (!strap_done_r) begin
      // strap caught on the first edge after reset release
      processor_mode_reg_nxt[`PMW_MPMC_BIT] = boot_mode_select_i;
      pc_load_nxt = 1'b1;
      pc_addr_nxt = `PMW_RESET_VEC;
    end else if (vec_req_i) begin
      pc_load_nxt = 1'b1;
      pc_addr_nxt = {processor_mode_reg_r[`PMW_VECTOR_PAGE_POINTER_MSB:`PMW_VECTOR_PAGE_POINTER_LSB], vec_num_i, 2'b00};
    end else if (far_ok) begin
      pc_load_nxt = 1'b1;
      pc_addr_nxt = far_target_i[15:0];
      xpc_nxt = far_target_i[19:16];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      processor_mode_reg_r <= `PMW_PROCESSOR_MODE_REG_RST;
      xpc_r <= `PMW_XPC_RST;
      wait_state_config_r <= `PMW_WAIT_STATE_CONFIG_RST;
      wait_multiplier_r <= `PMW_WAIT_MULTIPLIER_RST;
      strap_done_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_addr_r <= 16'h0000;
    end else begin
      processor_mode_reg_r <= processor_mode_reg_nxt;
      xpc_r <= xpc_nxt;
      wait_state_config_r <= wait_state_config_nxt;
      wait_multiplier_r <= wait_multiplier_nxt;
      strap_done_r <= strap_done_nxt;
      pc_load_r <= pc_load_nxt;
      pc_addr_r <= pc_addr_nxt;
    end
  end

  // access sequencer next state
  always_comb begin
    state_nxt = state_r;
    acc_ack_nxt = 1'b0;
    acc_rdata_nxt = acc_rdata_r;
    aux_ack_nxt = aux_req_i;
    aux_rdata_nxt = aux_hit ? ram_b_rd[aux_addr_i[BLK_AW]] : 16'h0000;
    ext_req_nxt = ext_req_r;
    ext_wr_nxt = ext_wr_r;
    ext_space_nxt = ext_space_r;
    ext_addr_nxt = ext_addr_r;
    ext_wdata_nxt = ext_wdata_r;
    unique case (state_r)
      PMW_ST_IDLE: begin
        if (take_ext) begin
          state_nxt = PMW_ST_EXT;
          ext_req_nxt = 1'b1;
          ext_wr_nxt = acc_wr_i;
          ext_space_nxt = acc_space_i;
          ext_addr_nxt = is_prog ? prog_addr : {4'h0, acc_addr_i};
          ext_wdata_nxt = acc_wdata_i;
        end else if (take) begin
          acc_ack_nxt = 1'b1;
          if (!acc_wr_i) begin
            if (hit_mmr) begin
              acc_rdata_nxt = mmr_rd;
            end else if (hit_ram) begin
              acc_rdata_nxt = ram_a_rd[acc_addr_i[BLK_AW]];
            end else begin
              acc_rdata_nxt = rom_rd;
            end
          end
        end
      end
      PMW_ST_EXT: begin
        if (ws_done) begin
          state_nxt = PMW_ST_IDLE;
          ext_req_nxt = 1'b0;
          acc_ack_nxt = 1'b1;
          if (!ext_wr_r) begin
            acc_rdata_nxt = ext_rdata_i;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= PMW_ST_IDLE;
      acc_ack_r <= 1'b0;
      acc_rdata_r <= 16'h0000;
      aux_ack_r <= 1'b0;
      aux_rdata_r <= 16'h0000;
      ext_req_r <= 1'b0;
      ext_wr_r <= 1'b0;
      ext_space_r <= 2'h0;
      ext_addr_r <= 20'h00000;
      ext_wdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      acc_ack_r <= acc_ack_nxt;
      acc_rdata_r <= acc_rdata_nxt;
      aux_ack_r <= aux_ack_nxt;
      aux_rdata_r <= aux_rdata_nxt;
      ext_req_r <= ext_req_nxt;
      ext_wr_r <= ext_wr_nxt;
      ext_space_r <= ext_space_nxt;
      ext_addr_r <= ext_addr_nxt;
      ext_wdata_r <= ext_wdata_nxt;
    end
  end

  always_comb begin
    acc_ack_o = acc_ack_r;
    acc_rdata_o = acc_rdata_r;
    aux_ack_o = aux_ack_r;
    aux_rdata_o = aux_rdata_r;
    pc_load_o = pc_load_r;
    pc_load_addr_o = pc_addr_r;
    prog_page_o = xpc_r;
    ext_req_o = ext_req_r;
    ext_wr_o = ext_wr_r;
    ext_space_o = ext_space_r;
    ext_addr_o = ext_addr_r;
    ext_wdata_o = ext_wdata_r;
  end

  AST_BOOT_VECTOR: assert property ($rose(strap_done_r) |-> pc_load_o && pc_load_addr_o == 16'hff80 &&
                                    prog_page_o == 4'h0)
    else $error("reset vector not at ff80 on page 0");
  AST_VEC_SLOT: assert property (strap_done_r && vec_req_i |=> pc_load_o &&
                                 pc_load_addr_o == {$past(processor_mode_reg_r[15:7]), $past(vec_num_i), 2'b00})
    else $error("vector address not pointer page plus four-word slot");
  AST_FAR_PAGE: assert property (far_ok |=> prog_page_o == $past(far_target_i[19:16]) &&
                                 pc_load_addr_o == $past(far_target_i[15:0]))
    else $error("far target not loaded into page and pc");
  AST_PAGE_STABLE: assert property (strap_done_r && !far_ok && !mmr_wr |=> $stable(prog_page_o))
    else $error("page changed without far load or register write");
  AST_FULL_ADDR: assert property (take_ext && is_prog && acc_full_i |=>
                                  ext_addr_o == {$past(acc_addr_hi_i), $past(acc_addr_i)})
    else $error("program transfer did not use full 20-bit address");
  AST_ROM_INTERNAL: assert property (take && hit_rom |=> acc_ack_o && !ext_req_o)
    else $error("rom access went to external bus");
  AST_OVERLAY: assert property (take && is_prog && ram_overlay_bit && acc_addr_i[15:14] == 2'b00 |=>
                                acc_ack_o && !ext_req_o)
    else $error("overlay program access not served by ram");
  AST_EXT_HOLD: assert property ($rose(ext_req_o) && $past(ws_cnt) == 4'd2 && $past(ws_gate) |->
                                 ext_req_o[*3])
    else $error("external access shorter than its wait count");

  COV_EXT_DONE: cover property ($fell(ext_req_o) ##0 acc_ack_o);
  COV_RELOC_VEC: cover property (vec_req_i && processor_mode_reg_r[15:7] != 9'h1ff);
  COV_FAR: cover property (far_ok && far_target_i[19:16] != 4'h0);
  COV_DUAL: cover property (take && hit_ram && acc_wr_i && aux_req_i && aux_hit);

endmodule // pmw_top

// File: hw/pmw_wait_gen.sv
// Purpose: wait-state down-counter for one external access at a time
// Assumes: start_i is a one-cycle pulse with the scaled count
// Notes: counter flop only advances while gate_en_i is high
`timescale 1ns/1ps
module pmw_wait_gen #(
  parameter int CW = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // control
  input wire logic start_i,
  input wire logic [CW-1:0] count_i,
  input wire logic ready_i,
  input wire logic gate_en_i,
  // status
  output logic done_o
);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  // assertion helper: loaded count and cycles since load
  logic [CW-1:0] load_r, load_nxt;
  logic [CW:0] age_r, age_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (start_i) begin
      cnt_nxt = count_i;
    end else if (busy_r && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    done_o = busy_r && ready_i && (cnt_r == '0 || !gate_en_i);
    busy_nxt = start_i ? 1'b1 : (done_o ? 1'b0 : busy_r);
    load_nxt = start_i ? count_i : load_r;
    age_nxt = age_r;
    if (start_i) begin
      age_nxt = '0;
    end else if (busy_r && age_r != '1) begin
      age_nxt = age_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      load_r <= '0;
      age_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      load_r <= load_nxt;
      age_r <= age_nxt;
      if (gate_en_i) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  AST_WAIT_LOAD: assert property (start_i && gate_en_i |=> cnt_r == $past(count_i))
    else $error("wait counter not loaded with scaled count");
  AST_NO_EARLY_DONE: assert property (done_o && gate_en_i |-> ready_i && age_r >= {1'b0, load_r})
    else $error("access completed before counter expired");
  AST_GATE_HOLD: assert property (!gate_en_i |=> cnt_r == $past(cnt_r))
    else $error("counter moved while gated off");
  AST_WAIT_MAX: assert property (busy_r |-> cnt_r <= `PMW_WAIT_MAX)
    else $error("wait count above fourteen");

endmodule // pmw_wait_gen

// File: tb/pmw_ext_mem.sv
// Purpose: external program, data and I/O memory with a ready line
// Assumes: request and qualifiers held until ready is seen high
// Notes: slow_i holds ready low for that many cycles of a request
`timescale 1ns/1ps
module pmw_ext_mem (
  // clock
  input wire logic sys_clk_i,
  // bus from the block
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [1:0] space_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  // answer
  input wire logic [3:0] slow_i,
  output logic [15:0] rdata_o,
  output logic ready_o
);
  logic [15:0] mem [0:255];
  logic [15:0] last_r = 16'h0000;
  logic [3:0] cnt_r = 4'h0;
  wire logic [7:0] idx = {space_i, addr_i[5:0]};
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h5a00 | 16'(i);
    end
  end
  assign ready_o = req_i && (cnt_r >= slow_i);
  // released bus shows the inverted last word
  assign rdata_o = req_i ? mem[idx] : ~last_r;
  always @(posedge sys_clk_i) begin
    if (req_i && ready_o) begin
      cnt_r <= 4'h0;
      last_r <= mem[idx];
      if (wr_i) begin
        mem[idx] <= wdata_i;
      end
    end else if (req_i) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // pmw_ext_mem

// File: tb/pmw_top_tb.sv
// Purpose: self-checking bench of memory map, vectors, page and waits
// Assumes: partner model answers every external access
// Notes: latency counts edges from the take edge to the visible ack
`timescale 1ns/1ps
module pmw_top_tb;
  import pmw_pkg::*;
  localparam logic [15:0] FILL = 16'ha5c3;
  localparam logic [1:0] P = 2'h0;
  localparam logic [1:0] D = 2'h1;
  localparam logic [1:0] IO = 2'h2;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic boot_mode_select_i = 1'b0;
  logic acc_req_i = 1'b0;
  logic [1:0] acc_space_i = 2'h0;
  logic acc_wr_i = 1'b0;
  logic acc_full_i = 1'b0;
  logic [3:0] acc_addr_hi_i = 4'h0;
  logic [15:0] acc_addr_i = 16'h0000;
  logic [15:0] acc_wdata_i = 16'h0000;
  logic aux_req_i = 1'b0;
  logic [15:0] aux_addr_i = 16'h0000;
  logic vec_req_i = 1'b0;
  logic [4:0] vec_num_i = 5'h00;
  logic far_load_i = 1'b0;
  logic [19:0] far_target_i = 20'h00000;
  logic [3:0] slow = 4'h0;
  logic acc_ack_o, aux_ack_o, pc_load_o, ext_req_o, ext_wr_o, ext_ready_i;
  logic [15:0] acc_rdata_o, aux_rdata_o, pc_load_addr_o, ext_wdata_o, ext_rdata_i;
  logic [3:0] prog_page_o;
  logic [1:0] ext_space_o;
  logic [19:0] ext_addr_o;
  int mismatches = 0;
  int compares = 0;
  int lat;
  logic [15:0] rd;
  logic [16:0] aux_seen;

  pmw_top #(.ROM_FILL(FILL)) i_pmw_top (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .boot_mode_select_i(boot_mode_select_i), .acc_req_i(acc_req_i), .acc_space_i(acc_space_i),
    .acc_wr_i(acc_wr_i), .acc_full_i(acc_full_i), .acc_addr_hi_i(acc_addr_hi_i),
    .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i), .acc_ack_o(acc_ack_o),
    .acc_rdata_o(acc_rdata_o), .aux_req_i(aux_req_i), .aux_addr_i(aux_addr_i),
    .aux_ack_o(aux_ack_o), .aux_rdata_o(aux_rdata_o), .vec_req_i(vec_req_i),
    .vec_num_i(vec_num_i), .far_load_i(far_load_i), .far_target_i(far_target_i),
    .pc_load_o(pc_load_o), .pc_load_addr_o(pc_load_addr_o), .prog_page_o(prog_page_o),
    .ext_req_o(ext_req_o), .ext_wr_o(ext_wr_o), .ext_space_o(ext_space_o),
    .ext_addr_o(ext_addr_o), .ext_wdata_o(ext_wdata_o), .ext_rdata_i(ext_rdata_i),
    .ext_ready_i(ext_ready_i));

  pmw_ext_mem i_pmw_ext_mem (.sys_clk_i(sys_clk_i), .req_i(ext_req_o), .wr_i(ext_wr_o),
    .space_i(ext_space_o), .addr_i(ext_addr_o), .wdata_i(ext_wdata_o), .slow_i(slow),
    .rdata_o(ext_rdata_i), .ready_o(ext_ready_i));

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one access; caller stands just after a rising edge
  task automatic acc(input logic [1:0] sp, input logic wr, input logic full,
                     input logic [19:0] a, input logic [15:0] wd);
    acc_req_i <= 1'b1;
    acc_space_i <= sp;
    acc_wr_i <= wr;
    acc_full_i <= full;
    acc_addr_hi_i <= a[19:16];
    acc_addr_i <= a[15:0];
    acc_wdata_i <= wd;
    @(posedge sys_clk_i);
    acc_req_i <= 1'b0;
    aux_req_i <= 1'b0;
    lat = 0;
    for (int k = 1; k <= 40 && lat == 0; k++) begin
      #1;
      if (k == 1) begin
        aux_seen = {aux_ack_o, aux_rdata_o};
      end
      if (acc_ack_o === 1'b1) begin
        lat = k;
        rd = acc_rdata_o;
      end
      @(posedge sys_clk_i);
    end
    if (lat == 0) begin
      mismatches++;
      end_of_test();
    end
  endtask

  task automatic rd_chk(input logic [1:0] sp, input logic full, input logic [19:0] a,
                        input logic [15:0] exp, input int exp_lat);
    acc(sp, 1'b0, full, a, 16'h0000);
    chk("read data", rd, exp);
    chk("latency", lat, exp_lat);
  endtask

  task automatic wr(input logic [1:0] sp, input logic [15:0] a, input logic [15:0] wd);
    acc(sp, 1'b1, 1'b0, {4'h0, a}, wd);
  endtask

  task automatic aux_go(input logic [15:0] a);
    aux_req_i <= 1'b1;
    aux_addr_i <= a;
  endtask

  // vector when v is high, far load otherwise
  task automatic flow(input logic v, input logic [4:0] n, input logic [19:0] t,
                      input logic [15:0] exp_pc, input logic [3:0] exp_pg);
    vec_req_i <= v;
    vec_num_i <= n;
    far_load_i <= !v;
    far_target_i <= t;
    @(posedge sys_clk_i);
    vec_req_i <= 1'b0;
    far_load_i <= 1'b0;
    #1;
    chk("pc load", pc_load_o, 1);
    chk("pc addr", pc_load_addr_o, exp_pc);
    chk("page", prog_page_o, exp_pg);
    @(posedge sys_clk_i);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk("reset pc load", pc_load_o, 1);
    chk("reset pc addr", pc_load_addr_o, 16'hff80);
    @(posedge sys_clk_i);
    rd_chk(D, 0, 20'h0001d, 16'hff80, 1);
    rd_chk(D, 0, 20'h0001e, 16'h0000, 1);
    rd_chk(D, 0, 20'h00028, 16'h7fff, 1);
    rd_chk(D, 0, 20'h0002b, 16'h0000, 1);
    rd_chk(D, 0, 20'h09000, 16'h5a40, 9);
    $display("test reset done");
    rd_chk(P, 0, 20'h0f123, FILL ^ 16'h0123, 1);
    rd_chk(P, 0, 20'h0ff10, 16'h0000, 1);
    wr(P, 16'hf123, 16'h1111);
    rd_chk(P, 0, 20'h0f123, FILL ^ 16'h0123, 1);
    $display("test rom done");
    wr(D, 16'h0080, 16'h1234);
    wr(D, 16'h3fff, 16'hbeef);
    wr(D, 16'h2000, 16'h0c0d);
    aux_go(16'h2000);
    rd_chk(D, 0, 20'h03fff, 16'hbeef, 1);
    chk("aux dual read", aux_seen, {1'b1, 16'h0c0d});
    aux_go(16'h2000);
    wr(D, 16'h2000, 16'h7777);
    chk("aux old word", aux_seen, {1'b1, 16'h0c0d});
    aux_go(16'h007f);
    rd_chk(D, 0, 20'h00080, 16'h1234, 1);
    chk("aux outside ram", aux_seen, {1'b1, 16'h0000});
    $display("test ram done");
    rd_chk(P, 1, 20'h00080, 16'h5a00, 9);
    wr(D, 16'h001d, 16'hffa0);
    rd_chk(P, 1, 20'h00080, 16'h1234, 1);
    rd_chk(P, 1, 20'h52000, 16'h7777, 1);
    wr(D, 16'h001d, 16'hff80);
    rd_chk(P, 1, 20'h52000, 16'h5a00, 9);
    chk("ext addr", ext_addr_o, 20'h52000);
    $display("test overlay done");
    flow(1'b1, 5'd3, 20'h0, 16'hff8c, 4'h0);
    wr(D, 16'h001d, 16'h1200);
    flow(1'b1, 5'd5, 20'h0, 16'h1214, 4'h0);
    flow(1'b0, 5'd0, 20'h71234, 16'h1234, 4'h7);
    flow(1'b1, 5'd2, 20'h0, 16'h1208, 4'h7);
    rd_chk(D, 0, 20'h0001e, 16'h0007, 1);
    rd_chk(P, 0, 20'h04000, 16'h5a00, 9);
    chk("ext addr", ext_addr_o, 20'h74000);
    wr(D, 16'h001e, 16'h0000);
    chk("page write", prog_page_o, 4'h0);
    $display("test vector and page done");
    wr(D, 16'h0028, 16'h14e5);
    rd_chk(D, 0, 20'h00028, 16'h14e5, 1);
    rd_chk(IO, 0, 20'h00010, 16'h5a90, 3);
    rd_chk(D, 0, 20'h09000, 16'h5a40, 4);
    rd_chk(D, 0, 20'h04000, 16'h5a40, 5);
    rd_chk(P, 0, 20'h08000, 16'h5a00, 6);
    rd_chk(P, 0, 20'h04000, 16'h5a00, 7);
    wr(D, 16'h002b, 16'h0001);
    rd_chk(D, 0, 20'h09000, 16'h5a40, 6);
    wr(D, 16'h0028, 16'h7000);
    rd_chk(IO, 0, 20'h00010, 16'h5a90, 16);
    wr(D, 16'h0028, 16'h8021);
    rd_chk(P, 0, 20'h08000, 16'h5a00, 4);
    wr(D, 16'h002b, 16'h0000);
    wr(D, 16'h0028, 16'h0000);
    rd_chk(D, 0, 20'h09000, 16'h5a40, 2);
    slow = 4'h5;
    rd_chk(D, 0, 20'h09000, 16'h5a40, 7);
    wr(D, 16'h0028, 16'h0600);
    slow = 4'h1;
    rd_chk(D, 0, 20'h09000, 16'h5a40, 5);
    slow = 4'h6;
    wr(D, 16'h9000, 16'h4321);
    chk("ext write", {ext_wr_o, ext_space_o, ext_wdata_o}, {1'b1, D, 16'h4321});
    chk("ext req idle", ext_req_o, 1'b0);
    rd_chk(D, 0, 20'h09000, 16'h4321, 8);
    $display("test wait states done");
    slow = 4'h0;
    flow(1'b0, 5'd0, 20'h30000, 16'h0000, 4'h3);
    boot_mode_select_i <= 1'b1;
    rstn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk("reboot pc addr", pc_load_addr_o, 16'hff80);
    chk("reboot page", prog_page_o, 4'h0);
    @(posedge sys_clk_i);
    rd_chk(D, 0, 20'h0001d, 16'hffc0, 1);
    rd_chk(P, 0, 20'h0f123, 16'h5a23, 9);
    rd_chk(D, 0, 20'h00028, 16'h7fff, 1);
    $display("test boot mode done");
    end_of_test();
  end
endmodule // pmw_top_tb
